/* verilog/gamma_dac_i2c_slave.sv */
// two-wire slave and twelve-channel double-buffered code registers
`timescale 1ns/1ps
module gamma_dac_i2c_slave (
  input wire logic sys_clk, // system clock, 125 MHz
  input wire logic rst, // async reset, high (power-up)
  input wire logic scl_in, // bus clock pin, input only
  input wire logic sda_in, // bus data pin level
  output logic sda_out, // data pin drive value, always low
  output logic sda_oe, // data pin pull-down enable
  input wire logic addr_select_pin, // low address bit
  input wire logic output_latch_pin, // high holds outputs until pin fall, bit 15 word or general-call reset
  output logic [gamma_pkg::CODE_W-1:0] ch_out [gamma_pkg::NUM_CH], // latched codes
  output logic hs_mode // high-speed filters on
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TX_ACK = 3'b101
  } state_e;

  gamma_pkg::bus_ev_s ev;
  state_e state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic ack_pend; // drive ack in coming ack slot
  logic is_read;
  logic gc_mode;
  logic have_ptr; // channel pointer byte received
  logic hi_done; // high byte of pair held
  logic [1:0] hi_bits;
  logic latch_req;
  logic [3:0] ptr;
  logic gc_reset;
  logic ld_q1;
  logic ld_q2;
  logic ld_prev;
  logic sel_q1; // address select pin, first flop
  logic sel_q2; // address select pin, safe to read
  logic [gamma_pkg::CODE_W-1:0] ch_reg [gamma_pkg::NUM_CH];
  logic [gamma_pkg::CODE_W-1:0] rd_word;

  ////////////////////////////////////////////////////////////////////
  // line monitor
  bus_monitor u_mon (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // open-drain data pin; there is no clock output at all
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // byte decode
  wire [7:0] rx_byte = {shift[6:0], ev.sda};
  wire byte_end = ev.scl_rise && bit_cnt == 3'd7;
  wire addr_me = rx_byte[7:2] == gamma_pkg::DEV_ADDR_HI && rx_byte[1] == sel_q2;
  wire addr_gc = rx_byte == gamma_pkg::GC_ADDR;
  wire addr_hs = rx_byte[7:3] == gamma_pkg::HS_CODE_HI;
  wire ptr_ok = rx_byte[3:0] <= gamma_pkg::CH_LAST;
  wire [3:0] ptr_next = (ptr == gamma_pkg::CH_LAST) ? 4'h0 : ptr + 4'h1;
  wire wr_low = byte_end && state == ST_RX && !gc_mode && have_ptr && hi_done;
  wire do_latch_all = wr_low && latch_req;
  wire ld_fall = ld_prev && !ld_q2;

  assign rd_word = ch_reg[ptr];

  // latch pin is a pin: two flops before use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ld_q1 <= 1'b1;
      ld_q2 <= 1'b1;
      ld_prev <= 1'b1;
      sel_q1 <= 1'b0;
      sel_q2 <= 1'b0;
    end else begin
      ld_q1 <= output_latch_pin;
      ld_q2 <= ld_q1;
      ld_prev <= ld_q2;
      sel_q1 <= addr_select_pin;
      sel_q2 <= sel_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // protocol state machine; samples on rising clock, drives on falling
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 3'd0;
      shift <= 8'h00;
      ack_pend <= 1'b0;
      is_read <= 1'b0;
      gc_mode <= 1'b0;
      have_ptr <= 1'b0;
      hi_done <= 1'b0;
      hi_bits <= 2'h0;
      latch_req <= 1'b0;
      ptr <= 4'h0;
      gc_reset <= 1'b0;
      hs_mode <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      gc_reset <= 1'b0;
      if (ev.stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        hs_mode <= 1'b0;
        hi_done <= 1'b0;
      end else if (ev.start) begin
        // repeated start keeps speed mode and pointer, drops half word
        state <= ST_ADDR;
        bit_cnt <= 3'd0;
        sda_oe <= 1'b0;
        hi_done <= 1'b0;
        gc_mode <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (ev.scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= bit_cnt + 3'd1;
            end
            if (byte_end) begin
              is_read <= rx_byte[0] && addr_me;
              gc_mode <= addr_gc;
              have_ptr <= have_ptr && rx_byte[0];
              if (addr_hs) begin
                hs_mode <= 1'b1;
                state <= ST_IDLE;
              end else if (addr_me || addr_gc) begin
                ack_pend <= 1'b1;
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            // pull low during the ninth clock, release on its falling edge
            if (ev.scl_fall) begin
              if (sda_oe) begin
                sda_oe <= 1'b0;
                if (is_read) begin
                  state <= ST_TX;
                  sda_oe <= 1'b1; // high byte msb is always zero
                end else begin
                  state <= ST_RX;
                end
                bit_cnt <= 3'd0;
              end else if (ack_pend) begin
                sda_oe <= 1'b1;
                ack_pend <= 1'b0;
              end else begin
                state <= ST_IDLE; // unacked byte: wait for next start
              end
            end
          end
          ST_RX: begin
            if (ev.scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= bit_cnt + 3'd1;
            end
            if (byte_end) begin
              state <= ST_ACK;
              if (gc_mode) begin
                ack_pend <= rx_byte == gamma_pkg::GC_RESET;
                gc_reset <= rx_byte == gamma_pkg::GC_RESET;
              end else if (!have_ptr) begin
                ack_pend <= ptr_ok;
                have_ptr <= ptr_ok;
                ptr <= rx_byte[3:0];
                hi_done <= 1'b0;
              end else if (!hi_done) begin
                ack_pend <= 1'b1;
                hi_done <= 1'b1;
                hi_bits <= rx_byte[1:0];
                latch_req <= rx_byte[gamma_pkg::LATCH_ALL_BIT];
              end else begin
                ack_pend <= 1'b1;
                hi_done <= 1'b0;
                ptr <= ptr_next;
              end
            end
          end
          ST_TX: begin
            // bit 7 already driven at ack fall; rest shift on each fall
            if (ev.scl_fall) begin
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7) begin
                sda_oe <= 1'b0;
                state <= ST_TX_ACK;
              end else begin
                sda_oe <= hi_done ? !rd_word[6 - bit_cnt] :
                          (bit_cnt < 3'd5 ? 1'b1 : !rd_word[4'd14 - 4'(bit_cnt)]);
              end
            end
          end
          ST_TX_ACK: begin
            if (ev.scl_rise) begin
              if (ev.sda) begin
                state <= ST_IDLE;
              end else begin
                bit_cnt <= 3'd0;
                if (hi_done) begin
                  hi_done <= 1'b0;
                  ptr <= ptr_next;
                end else begin
                  hi_done <= 1'b1;
                end
              end
            end
            if (ev.scl_fall && state == ST_TX_ACK) begin
              state <= ST_TX;
              sda_oe <= hi_done ? !rd_word[7] : 1'b1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
      if (gc_reset) begin
        hs_mode <= 1'b0;
        ptr <= 4'h0;
        have_ptr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channel storage and output latches, one per channel
  generate
    for (genvar i = 0; i < gamma_pkg::NUM_CH; i++) begin : g_ch
      wire wr_this = wr_low && ptr == 4'(i);
      wire [gamma_pkg::CODE_W-1:0] new_code = {hi_bits, rx_byte};
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          ch_reg[i] <= gamma_pkg::RESET_CODE[i];
        end else if (gc_reset) begin
          ch_reg[i] <= gamma_pkg::RESET_CODE[i];
        end else if (wr_this) begin
          ch_reg[i] <= new_code;
        end
      end
      // output stage follows on pin-low write, pin fall, or bit 15 word
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          ch_out[i] <= gamma_pkg::RESET_CODE[i];
        end else if (gc_reset) begin
          ch_out[i] <= gamma_pkg::RESET_CODE[i];
        end else if (wr_this && (!ld_q2 || latch_req)) begin
          ch_out[i] <= new_code;
        end else if (ld_fall || do_latch_all || (!ld_q2 && !ld_prev)) begin
          ch_out[i] <= ch_reg[i];
        end
      end
    end
  endgenerate
endmodule : gamma_dac_i2c_slave

/* include/gamma_pkg.sv */
// shared constants and types for the gamma reference two-wire slave
package gamma_pkg;
  localparam int NUM_CH = 12;
  localparam int CODE_W = 10;
  localparam logic [5:0] DEV_ADDR_HI = 6'h3a; // 111010x
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [4:0] HS_CODE_HI = 5'h01; // 00001xxx
  localparam logic [3:0] CH_LAST = 4'hb;
  localparam int LATCH_ALL_BIT = 7; // bit 15 of the word, bit 7 of the high byte
  localparam logic [CODE_W-1:0] RESET_CODE [NUM_CH] = '{
    10'h3e0, 10'h360, 10'h320, 10'h300, 10'h2c0, 10'h240,
    10'h1c0, 10'h140, 10'h100, 10'h0e0, 10'h0a0, 10'h020};
  // one decoded bus event from the line monitor
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } bus_ev_s;
endpackage : gamma_pkg

/* verilog/bus_monitor.sv */
// synchroniser and start/stop/edge detector for the two bus lines
`timescale 1ns/1ps
module bus_monitor (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic scl_in, // bus clock pin
  input wire logic sda_in, // bus data pin
  output gamma_pkg::bus_ev_s ev // decoded events, one-cycle pulses, plus the synced data level
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  gamma_pkg::bus_ev_s next_ev;

  ////////////////////////////////////////////////////////////////////
  // two flops per pin, then one more stage for edge finding
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  // data edge while clock high marks start or stop
  assign next_ev.start = scl_q && scl_sync[1] && sda_q && !sda_sync[1];
  assign next_ev.stop = scl_q && scl_sync[1] && !sda_q && sda_sync[1];
  assign next_ev.scl_rise = !scl_q && scl_sync[1];
  assign next_ev.scl_fall = scl_q && !scl_sync[1];
  assign next_ev.sda = sda_sync[1];

  // registered so the core sees clean pulses
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev <= '{default: 1'b0, sda: 1'b1};
    end else begin
      ev <= next_ev;
    end
  end
endmodule : bus_monitor

/* test/gamma_dac_i2c_slave_properties.sv */
// checker of timing relations at the gamma slave pins
`timescale 1ns/1ps
module gamma_dac_i2c_slave_properties (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic scl_in, // bus clock
  input wire logic sda_in, // bus data
  input wire logic sda_out, // drive value
  input wire logic sda_oe, // pull-down enable
  input wire logic addr_select_pin, // address bit
  input wire logic output_latch_pin, // hold
  input wire logic [gamma_pkg::CODE_W-1:0] ch_out [gamma_pkg::NUM_CH], // codes
  input wire logic hs_mode // fast filters
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // data-to-clock timing is left unchecked in high speed (short low time, sync delay); release within 200 clocks is checked in all modes
  drive_low_a: assert property (sda_out == 1'b0)
    else $error("drive value high");
  reset_codes_a: assert property ($fell(rst) |-> ch_out[0] == 10'h3e0
    && ch_out[5] == 10'h240 && ch_out[11] == 10'h020) else $error("bad reset codes");
  reset_idle_a: assert property ($fell(rst) |-> !sda_oe && !hs_mode)
    else $error("busy after reset");
  oe_clock_low_a: assert property (!hs_mode && $changed(sda_oe) |-> !scl_in)
    else $error("data moved with clock high");
  ack_hold_a: assert property ($rose(sda_oe) && !hs_mode |-> (!scl_in) [*3])
    else $error("answer too late");
  oe_release_a: assert property (sda_oe |-> ##[1:200] !sda_oe)
    else $error("data held low");
  hs_stop_exit_a: assert property ($fell(hs_mode) |-> scl_in && sda_in)
    else $error("high speed left off stop");
  hs_no_ack_a: assert property ($rose(hs_mode) |-> (!sda_oe) [*8])
    else $error("master code acked");
endmodule : gamma_dac_i2c_slave_properties
bind gamma_dac_i2c_slave gamma_dac_i2c_slave_properties u_props (.sys_clk(sys_clk),
  .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_select_pin(addr_select_pin), .output_latch_pin(output_latch_pin),
  .ch_out(ch_out), .hs_mode(hs_mode));

/* test/i2c_master_model.sv */
// behavioural two-wire bus master paced on the system clock
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic sys_clk, // pacing clock
  input wire logic sda, // resolved data line
  output logic scl, // bus clock, driven here only
  output logic sda_low // pulls data low
);
  int h = 8; // half period in clocks
  // clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // start or repeated start: data falls with clock high
  task automatic start();
    sda_low = 1'b0;
    wt(h);
    scl = 1'b1;
    wt(h);
    sda_low = 1'b1;
    wt(h);
    scl = 1'b0;
  endtask : start
  // stop: data rises with clock high
  task automatic stop();
    wt(1);
    sda_low = 1'b1;
    wt(h);
    scl = 1'b1;
    wt(h);
    sda_low = 1'b0;
    wt(h);
  endtask : stop
  // data moves a clock after scl falls, so no edge races the clock
  task automatic clk_bit(input logic b, output logic s);
    wt(1);
    sda_low = !b;
    wt(h - 1);
    scl = 1'b1;
    wt(h);
    s = sda;
    scl = 1'b0;
  endtask : clk_bit
  // eight bits msb first, then the receiver's ninth bit
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
      q[i] = s;
    end
    clk_bit(nine, s);
    ack = !s;
  endtask : xfer
endmodule : i2c_master_model

/* test/test_gamma_dac_i2c_slave.sv */
// self-checking bench for the gamma two-wire slave
`timescale 1ns/1ps
module test_gamma_dac_i2c_slave;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic addr_select_pin = 1'b0;
  logic output_latch_pin = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic hs_mode;
  logic [gamma_pkg::CODE_W-1:0] ch_out [gamma_pkg::NUM_CH];
  logic [9:0] img [12]; // expected outputs
  int errors = 0;
  int num_checks = 0;
  // rows: address select, address byte, pointer, word
  logic [32:0] rows [6] = '{33'h0_e8_00_0155, 33'h1_ea_0b_02aa, 33'h0_ea_03_0111,
    33'h1_e8_03_0122, 33'h0_e8_0c_0133, 33'h0_e8_05_7dff};
  wire sda_line = !((sda_oe && !sda_out) || sda_low); // pull-up
  always #4 sys_clk = ~sys_clk;
  gamma_dac_i2c_slave DUT (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(addr_select_pin),
    .output_latch_pin(output_latch_pin), .ch_out(ch_out), .hs_mode(hs_mode));
  i2c_master_model m (.sys_clk(sys_clk), .sda(sda_line), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic put(input logic [7:0] d, input logic exp);
    logic [7:0] q;
    logic a;
    m.xfer(d, 1'b1, q, a);
    check("ack", a, exp);
  endtask : put
  // nine is the master's own answer: low acks, high ends the read
  task automatic get(input logic nine, input logic [7:0] exp);
    logic [7:0] q;
    logic a;
    m.xfer(8'hff, nine, q, a);
    check("read", q, exp);
  endtask : get
  task automatic ww(input logic [15:0] w);
    put(w[15:8], 1'b1);
    put(w[7:0], 1'b1);
  endtask : ww
  task automatic open(input logic [7:0] p);
    m.start();
    put(8'he8, 1'b1);
    put(p, 1'b1);
  endtask : open
  task automatic chk_all();
    for (int c = 0; c < 12; c++) begin
      check("ch_out", ch_out[c], img[c]);
    end
  endtask : chk_all
  task automatic reset_img();
    img = '{10'h3e0, 10'h360, 10'h320, 10'h300, 10'h2c0, 10'h240,
      10'h1c0, 10'h140, 10'h100, 10'h0e0, 10'h0a0, 10'h020};
  endtask : reset_img
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: table rows first, then the awkward cases
  initial begin
    logic [7:0] a;
    logic [7:0] p;
    logic [15:0] w;
    logic ok;
    reset_img();
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    m.wt(4);
    chk_all();
    check("hs", hs_mode, 1'b0);
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      {addr_select_pin, a, p, w} = rows[r];
      ok = a[7:1] == {6'b111010, addr_select_pin};
      m.start();
      put(a, ok);
      if (ok) begin
        put(p, p < 8'h0c);
      end
      if (ok && p < 8'h0c) begin
        ww(w);
        img[p[3:0]] = w[9:0];
      end
      m.stop();
      chk_all();
    end
    $display("test table done");
    open(8'h0a);
    for (int c = 10; c < 13; c++) begin
      ww(16'(16'h0300 + c));
      img[c % 12] = 10'(10'h300 + c);
    end
    open(8'h0b);
    m.start();
    put(8'he9, 1'b1);
    get(1'b0, {6'h00, img[11][9:8]});
    get(1'b0, img[11][7:0]);
    get(1'b0, {6'h00, img[0][9:8]});
    get(1'b1, img[0][7:0]);
    m.stop();
    open(8'h02);
    put(8'h01, 1'b1);
    open(8'h03);
    put(8'h01, 1'b1);
    m.stop();
    chk_all();
    $display("test sequence done");
    output_latch_pin = 1'b1;
    open(8'h01);
    ww(16'h0111);
    m.stop();
    chk_all();
    output_latch_pin = 1'b0;
    m.wt(5);
    img[1] = 10'h111;
    chk_all();
    output_latch_pin = 1'b1;
    open(8'h03);
    ww(16'h0133);
    ww(16'h8044);
    m.stop();
    img[3] = 10'h133;
    img[4] = 10'h044;
    chk_all();
    m.start();
    put(8'h00, 1'b1);
    put(8'h05, 1'b0);
    m.stop();
    chk_all();
    m.start();
    put(8'h00, 1'b1);
    put(8'h06, 1'b1);
    m.stop();
    reset_img();
    chk_all();
    output_latch_pin = 1'b0;
    $display("test latch done");
    for (int x = 0; x < 8; x++) begin
      m.start();
      put({5'b00001, 3'(x)}, 1'b0);
      m.start();
      check("hs", hs_mode, 1'b1);
      m.h = 4;
      put(8'he8, 1'b1);
      put(8'(x), 1'b1);
      ww(16'(16'h0200 + x));
      img[x] = 10'(10'h200 + x);
      m.start();
      check("hs", hs_mode, 1'b1);
      m.stop();
      m.h = 8;
      m.wt(4);
      check("hs", hs_mode, 1'b0);
    end
    chk_all();
    $display("test high speed done");
    tally_and_finish();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
endmodule : test_gamma_dac_i2c_slave
